// [shared/wwd_pkg.sv]
/*
  Window watchdog package: register offsets, field positions, reset values
  and the derived default reload. Assumes a 32-bit APB register bus.
*/
`default_nettype none
package wwd_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] WWD_CTRL_OFS   = 8'h00;
  localparam logic [7:0] WWD_RELOAD_OFS = 8'h04;
  localparam logic [7:0] WWD_WINDOW_OFS = 8'h08;
  localparam logic [7:0] WWD_COUNT_OFS  = 8'h0C;
  localparam logic [7:0] WWD_CMD_OFS    = 8'h10;
  localparam logic [7:0] WWD_STATUS_OFS = 8'h14;
  localparam logic [7:0] WWD_CLEAR_OFS  = 8'h18;
  localparam logic [7:0] WWD_IRQEN_OFS  = 8'h1C;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int WWD_CTRL_SRC_BIT  = 0;  // 1: wake-up oscillator, 0: system clock
  localparam int WWD_CTRL_DIV_BIT  = 1;  // 1: divide by 256, 0: by 16384
  localparam int WWD_CTRL_EN_BIT   = 8;  // read-only running flag
  localparam int WWD_CMD_SRV_BIT   = 0;
  localparam int WWD_CMD_DIS_BIT   = 1;
  localparam int WWD_CMD_ENA_BIT   = 2;
  localparam int WWD_EVT_OVF_BIT   = 0;
  localparam int WWD_EVT_EARLY_BIT = 1;
  localparam int WWD_EVT_W         = 2;
  localparam int WWD_CNT_W         = 16;
  localparam int WWD_PRE_W         = 14;
  // ----------------------------------------------------------------
  // Prescaler terminal counts
  // ----------------------------------------------------------------
  localparam logic [13:0] WWD_PRE_MAX_16K = 14'h3FFF;
  localparam logic [13:0] WWD_PRE_MAX_256 = 14'h00FF;
  localparam int          WWD_DIV_SLOW    = 16384;
  localparam int          WWD_DIV_FAST    = 256;
  // ----------------------------------------------------------------
  // Power-up defaults: wake-up source, divide by 256, 0.13 s at 500 kHz
  // ----------------------------------------------------------------
  localparam int WWD_WU_KHZ       = 500;
  localparam int WWD_DEF_IVAL_US  = 130000;
  localparam int WWD_DEF_TICKS    =
    (WWD_DEF_IVAL_US * WWD_WU_KHZ + WWD_DIV_FAST * 500) / (WWD_DIV_FAST * 1000);
  localparam logic [15:0] WWD_RELOAD_RST = 16'(65536 - WWD_DEF_TICKS);
  localparam logic [15:0] WWD_WINDOW_RST = 16'h0000;
  localparam logic        WWD_SRC_RST    = 1'b1;
  localparam logic        WWD_DIV_RST    = 1'b1;
  localparam logic [15:0] WWD_CNT_MAX    = 16'hFFFF;
endpackage
`default_nettype wire

// [design/wwd_top.sv]
/*
  Windowed 16-bit watchdog with APB register slave and interrupt.
  Assumes a 200 MHz clk, wakeup_osc_clock synchronous to clk and slower
  than clk/2, and an external reset unit acting on wwd_rst_req.
*/
// Decided for this implementation: register access over APB and the register offsets.
// Notes on behaviour
// R1: Watchdog comes out of every reset enabled and counting without software help.
// R2: Disable command stops the count, enable command restarts it, accepted any time.
// R3: Overflow while enabled raises the reset request; software must service before.
// R4: Refresh while count is below the window boundary also raises reset request.
// R5: 16-bit counter ticks from system or wake-up clock divided by 16384 or 256.
// R6: Each valid service loads the counter with the reload register value.
// R7: Power-up defaults give about 0.13 s with a 500 kHz wake-up clock.
// R8: Count up from reload, overflow on wrap past all ones, window checked at refresh.
`timescale 1ns/1ps
`default_nettype none
module wwd_top
  import wwd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        wakeup_osc_clock,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic        wwd_rst_req,
  output var  logic        wwd_irq
);
  import wwd_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0]           cnt_r;
  logic [15:0]           reload_r;
  logic [15:0]           window_r;
  logic [13:0]           pre_r;
  logic                  en_r;
  logic                  src_r;
  logic                  div_r;
  logic                  wu_q_r;
  logic [WWD_EVT_W-1:0]  sts_r;
  logic [WWD_EVT_W-1:0]  irqen_r;
  logic                  wr_acc;
  logic                  srv_cmd;
  logic                  dis_cmd;
  logic                  ena_cmd;
  logic                  src_tick;
  logic                  pre_end;
  logic                  tick;
  logic                  ovf_evt;
  logic                  early_evt;
  logic                  srv_ok;
  logic [WWD_EVT_W-1:0]  evt;
  logic                  clr_wr;
  logic                  irq_nxt;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign wr_acc  = psel && penable && pwrite && pready;
  assign srv_cmd = wr_acc && (paddr == WWD_CMD_OFS) && pwdata[WWD_CMD_SRV_BIT];
  assign dis_cmd = wr_acc && (paddr == WWD_CMD_OFS) && pwdata[WWD_CMD_DIS_BIT];
  assign ena_cmd = wr_acc && (paddr == WWD_CMD_OFS) && pwdata[WWD_CMD_ENA_BIT];
  assign clr_wr  = wr_acc && (paddr == WWD_CLEAR_OFS);

  // One wait-free access: ready rises on the setup edge
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      pready <= 1'b0;
    else
      pready <= psel && !penable;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      if (paddr == WWD_CTRL_OFS)
      begin
        prdata[WWD_CTRL_SRC_BIT] <= src_r;
        prdata[WWD_CTRL_DIV_BIT] <= div_r;
        prdata[WWD_CTRL_EN_BIT]  <= en_r;
      end
      else if (paddr == WWD_RELOAD_OFS)
        prdata[15:0] <= reload_r;
      else if (paddr == WWD_WINDOW_OFS)
        prdata[15:0] <= window_r;
      else if (paddr == WWD_COUNT_OFS)
        prdata[15:0] <= cnt_r;
      else if (paddr == WWD_STATUS_OFS)
        prdata[WWD_EVT_W-1:0] <= sts_r;
      else if (paddr == WWD_IRQEN_OFS)
        prdata[WWD_EVT_W-1:0] <= irqen_r;
      else if (paddr == WWD_CMD_OFS || paddr == WWD_CLEAR_OFS)
        prdata <= 32'h0000_0000;
      else
        pslverr <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      src_r <= WWD_SRC_RST;      // see R7
      div_r <= WWD_DIV_RST;      // see R7
    end
    else if (wr_acc && paddr == WWD_CTRL_OFS)
    begin
      src_r <= pwdata[WWD_CTRL_SRC_BIT];
      div_r <= pwdata[WWD_CTRL_DIV_BIT];
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      reload_r <= WWD_RELOAD_RST;  // see R7
    else if (wr_acc && paddr == WWD_RELOAD_OFS)
      reload_r <= pwdata[15:0];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      window_r <= WWD_WINDOW_RST;
    else if (wr_acc && paddr == WWD_WINDOW_OFS)
      window_r <= pwdata[15:0];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      irqen_r <= '0;
    else if (wr_acc && paddr == WWD_IRQEN_OFS)
      irqen_r <= pwdata[WWD_EVT_W-1:0];
  end

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  // Disable wins if both commands arrive in one write
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      en_r <= 1'b1;              // see R1
    else if (dis_cmd)
      en_r <= 1'b0;              // see R2
    else if (ena_cmd)
      en_r <= 1'b1;              // see R2
  end

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      wu_q_r <= 1'b0;
    else
      wu_q_r <= wakeup_osc_clock;
  end

  assign src_tick = src_r ? (wakeup_osc_clock && !wu_q_r) : 1'b1;   // see R5
  assign pre_end  = div_r ? ((pre_r & WWD_PRE_MAX_256) == WWD_PRE_MAX_256)
                          : (pre_r == WWD_PRE_MAX_16K);             // see R5
  assign tick     = en_r && src_tick && pre_end;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      pre_r <= '0;
    else if (!en_r)
      pre_r <= '0;
    else if (src_tick)
      pre_r <= pre_r + 14'h0001;
  end

  // ----------------------------------------------------------------
  // Counter, window and events
  // ----------------------------------------------------------------
  assign early_evt = srv_cmd && en_r && (cnt_r < window_r);        // see R4 R8
  assign srv_ok    = srv_cmd && en_r && !(cnt_r < window_r);
  assign ovf_evt   = tick && (cnt_r == WWD_CNT_MAX);                // see R3 R8

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_r <= WWD_RELOAD_RST;
    else if (srv_ok || ovf_evt)
      cnt_r <= reload_r;         // see R6 R8
    else if (tick)
      cnt_r <= cnt_r + 16'h0001; // see R5 R8
  end

  // Request holds until the reset it asks for arrives
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      wwd_rst_req <= 1'b0;
    else if (ovf_evt || early_evt)
      wwd_rst_req <= 1'b1;       // see R3 R4
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  always_comb
  begin
    evt = '0;
    evt[WWD_EVT_OVF_BIT]   = ovf_evt;
    evt[WWD_EVT_EARLY_BIT] = early_evt;
  end

  // New event beats a simultaneous clear
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      sts_r <= '0;
    else if (clr_wr)
      sts_r <= (sts_r & ~pwdata[WWD_EVT_W-1:0]) | evt;
    else
      sts_r <= sts_r | evt;
  end

  assign irq_nxt = |((sts_r | evt) & irqen_r);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      wwd_irq <= 1'b0;
    else if (clr_wr)
      wwd_irq <= |(((sts_r & ~pwdata[WWD_EVT_W-1:0]) | evt) & irqen_r);
    else
      wwd_irq <= irq_nxt;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  enabled_after_reset_a: assert property ($past(sys_rst) |-> en_r) // see R1
    else $error("watchdog not enabled after reset");
  disable_cmd_a: assert property (dis_cmd |=> !en_r) // see R2
    else $error("disable command ignored");
  enable_cmd_a: assert property (ena_cmd && !dis_cmd |=> en_r) // see R2
    else $error("enable command ignored");
  stopped_hold_a: assert property (!en_r && !ena_cmd |=> $stable(cnt_r)) // see R2
    else $error("counter moved while stopped");
  overflow_req_a: assert property (en_r && cnt_r == WWD_CNT_MAX && tick |=> wwd_rst_req) // see R3
    else $error("overflow without reset request");
  early_req_a: assert property (srv_cmd && en_r && cnt_r < window_r |=> wwd_rst_req) // see R4
    else $error("early refresh without reset request");
  tick_cause_a: assert property (cnt_r != $past(cnt_r) |-> $past(tick || srv_ok)) // see R5
    else $error("counter moved without tick or service");
  service_load_a: assert property (srv_ok |=> cnt_r == $past(reload_r)) // see R6
    else $error("service did not load reload value");
  reset_defaults_a: assert property ($past(sys_rst) |-> reload_r == WWD_RELOAD_RST
                                     && src_r && div_r) // see R7
    else $error("power-up defaults wrong");
  wrap_reload_a: assert property (ovf_evt |=> cnt_r == $past(reload_r)) // see R8
    else $error("overflow did not reload");
  req_sticky_a: assert property (wwd_rst_req |=> wwd_rst_req) // see R3
    else $error("reset request dropped");

  overflow_c: cover property (ovf_evt);
  early_c: cover property (early_evt);
  good_service_c: cover property (srv_ok ##[1:20] tick);
  restart_c: cover property (dis_cmd ##[1:50] ena_cmd);
endmodule
`default_nettype wire

// [test/wwd_top_bench.sv]
/*
  Self-checking bench for the window watchdog: register access over APB,
  overflow, early refresh, disable and enable, interrupt masking and clear.
  Assumes wwd_top and wwd_pkg; the bench drives every port itself.
*/
`timescale 1ns/1ps
`default_nettype none
module wwd_top_bench;
  import wwd_pkg::*;
  localparam int CEIL = 40000;
  logic        clk         = 1'b0;
  logic        sys_rst     = 1'b1;
  logic [1:0]  wu_div      = 2'h0;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [7:0]  paddr       = 8'h00;
  logic [31:0] pwdata      = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wwd_rst_req;
  logic        wwd_irq;
  logic [31:0] rd;
  logic        last_err;
  int          num_errors  = 0;
  int          comparisons = 0;
  int          cycles      = 0;

  // ----------------------------------------------------------------
  // Clock, wake-up source at clk/4, run limit
  // ----------------------------------------------------------------
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    wu_div <= wu_div + 2'h1;
    cycles <= cycles + 1;
    if (cycles == CEIL)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  wwd_top i_dut (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .wakeup_osc_clock (wu_div[1]),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .wwd_rst_req      (wwd_rst_req),
    .wwd_irq          (wwd_irq)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd       = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits up to n cycles for the reset request, then compares
  task automatic wait_req(input int n, input logic exp);
    for (int i = 0; i < n && wwd_rst_req !== 1'b1; i++)
      @(posedge clk);
    check(wwd_rst_req, exp);
  endtask

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults();
    do_reset();
    apb(0, WWD_CTRL_OFS, 0);
    check(rd, 32'h00000103);
    apb(0, WWD_RELOAD_OFS, 0);
    check(rd, 32'h0000FF02);
    repeat (1400) @(posedge clk);
    apb(0, WWD_COUNT_OFS, 0);
    check(rd, 32'h0000FF03);
    apb(1, WWD_COUNT_OFS, 32'h00001234);
    apb(0, WWD_COUNT_OFS, 0);
    check(rd, 32'h0000FF03);
    apb(0, 8'h20, 0);
    check(last_err, 1'b1);
  endtask

  task automatic t_overflow();
    do_reset();
    apb(1, WWD_CTRL_OFS, 32'h2);
    apb(1, WWD_RELOAD_OFS, 32'hFFFE);
    apb(1, WWD_IRQEN_OFS, 32'h1);
    apb(1, WWD_CMD_OFS, 32'h1);
    apb(0, WWD_COUNT_OFS, 0);
    check(rd & 32'hFFFFFFFE, 32'h0000FFFE);
    wait_req(200, 1'b0);
    wait_req(600, 1'b1);
    apb(0, WWD_STATUS_OFS, 0);
    check(rd, 32'h1);
    check(wwd_irq, 1'b1);
    apb(1, WWD_CLEAR_OFS, 32'h1);
    apb(0, WWD_STATUS_OFS, 0);
    check(rd, 32'h0);
    check(wwd_irq, 1'b0);
  endtask

  task automatic t_early();
    do_reset();
    apb(1, WWD_CTRL_OFS, 32'h2);
    apb(1, WWD_RELOAD_OFS, 32'hFFF0);
    apb(1, WWD_CMD_OFS, 32'h1);
    apb(1, WWD_WINDOW_OFS, 32'hFFF8);
    check(wwd_rst_req, 1'b0);
    apb(1, WWD_CMD_OFS, 32'h1);
    wait_req(3, 1'b1);
    apb(0, WWD_STATUS_OFS, 0);
    check(rd, 32'h2);
    check(wwd_irq, 1'b0);
    apb(1, WWD_IRQEN_OFS, 32'h2);
    apb(0, WWD_WINDOW_OFS, 0);
    check(rd, 32'h0000FFF8);
    check(wwd_irq, 1'b1);
  endtask

  task automatic t_window_ok();
    do_reset();
    apb(1, WWD_CTRL_OFS, 32'h2);
    apb(1, WWD_RELOAD_OFS, 32'hFFF0);
    apb(1, WWD_CMD_OFS, 32'h1);
    apb(1, WWD_WINDOW_OFS, 32'hFFF2);
    repeat (700) @(posedge clk);
    apb(1, WWD_CMD_OFS, 32'h1);
    apb(0, WWD_COUNT_OFS, 0);
    check(rd & 32'hFFFFFFFE, 32'h0000FFF0);
    check(wwd_rst_req, 1'b0);
  endtask

  // System clock divided by 16384: no overflow early, one right after
  task automatic t_slow_div();
    do_reset();
    apb(1, WWD_CTRL_OFS, 32'h0);
    apb(1, WWD_RELOAD_OFS, 32'hFFFF);
    apb(1, WWD_CMD_OFS, 32'h1);
    wait_req(16000, 1'b0);
    wait_req(800, 1'b1);
    apb(0, WWD_STATUS_OFS, 0);
    check(rd, 32'h1);
  endtask

  task automatic t_disable();
    do_reset();
    apb(1, WWD_CTRL_OFS, 32'h2);
    apb(1, WWD_RELOAD_OFS, 32'hFFFE);
    apb(1, WWD_CMD_OFS, 32'h1);
    apb(1, WWD_CMD_OFS, 32'h2);
    apb(0, WWD_CTRL_OFS, 0);
    check(rd, 32'h2);
    wait_req(1200, 1'b0);
    apb(1, WWD_CMD_OFS, 32'h6);
    apb(0, WWD_CTRL_OFS, 0);
    check(rd, 32'h2);
    apb(1, WWD_CMD_OFS, 32'h4);
    apb(0, WWD_CTRL_OFS, 0);
    check(rd, 32'h102);
    wait_req(800, 1'b1);
  endtask

  initial
  begin
    t_defaults();
    t_overflow();
    t_early();
    t_window_ok();
    t_slow_div();
    t_disable();
    report_and_stop();
  end
endmodule
`default_nettype wire
